// *** ulri_defs.vh ***
// Constants for the USB device length-result and interrupt-enable block.
// Assumes a 32-bit APB slave port; registers sit in the low 16 bits of each word.
`ifndef ULRI_DEFS_VH
`define ULRI_DEFS_VH
`define ULRI_DW               16
`define ULRI_AW               16
`define ULRI_OFF_IEN1         16'hc08c
`define ULRI_OFF_IEN2         16'hc0ac
`define ULRI_OFF_STAT1        16'hc090
`define ULRI_OFF_STAT2        16'hc0b0
`define ULRI_OFF_RES_BASE     16'hc100
`define ULRI_OFF_RES_END      16'hc11c
`define ULRI_OFF_EPST_BASE    16'hc120
`define ULRI_OFF_EPST_END     16'hc13c
`define ULRI_OFF_FRAME1       16'hc140
`define ULRI_OFF_FRAME2       16'hc144
`define ULRI_IEN_RST          16'h0000
`define ULRI_IEN1_MASK        16'hcbff
`define ULRI_IEN2_MASK        16'h0bff
`define ULRI_BIT_VBUS         15
`define ULRI_BIT_ID           14
`define ULRI_BIT_SOFTO        11
`define ULRI_BIT_SOF          9
`define ULRI_BIT_URST         8
`define ULRI_ST_OVF           11
`define ULRI_ST_UNF           10
`define ULRI_ST_OUTX          9
`define ULRI_ST_INX           8
`define ULRI_ST_STALL         7
`define ULRI_ST_NAK           6
`define ULRI_ST_LEN           5
`define ULRI_ST_TMO           2
`define ULRI_ST_ERR           1
`define ULRI_ST_ACK           0
`define ULRI_EPS              8
`define ULRI_EPW              3
`define ULRI_ZERO16           16'h0000
`define ULRI_ZERO32           32'h0000_0000
`endif

// *** ulri_mem.v ***
// Small result memory: one 16-bit word per endpoint and device port.
// Assumes a single writer per cycle chosen by the top; read data registered.
`timescale 1ns/1ns
module ulri_mem #(
  parameter AW = 4,
  parameter DW = 16
) (
  input  wire          mclk,
  input  wire          we,
  input  wire [AW-1:0] waddr,
  input  wire [DW-1:0] wdata,
  input  wire [AW-1:0] raddr,
  output reg  [DW-1:0] rdata
);
  reg [DW-1:0] mem_r [0:(1<<AW)-1];

  // No reset: the words are meant to be cleared by firmware before use.
  always @(posedge mclk)
  begin
    if (we)
    begin
      mem_r[waddr] <= wdata;
    end
    rdata <= mem_r[raddr];
  end
endmodule // ulri_mem

// *** ulri_top.v ***
// USB device length-result store, endpoint status and device interrupt enables.
// Assumes an APB master at mclk and an engine that reports per-packet events.
`timescale 1ns/1ns
`include "ulri_defs.vh"
// Overview of operation
// [R1] Store count minus received length, 16 bits.
// [R2] Length mismatch sets length exception flag.
// [R3] Firmware reads result only if length-only exception.
// [R4] Firmware zeroes result once, never again.
// [R5] Overflow stores negative two's complement excess.
// [R6] Underflow stores positive unused byte count.
// [R7] Enable bit 15 gates VBUS both edges.
// [R8] Enable bit 14 gates ID both edges.
// [R9] VBUS and ID exist only on first device.
// [R10] Enable bit 11 gates SOF/EOP timeout.
// [R11] Frame count counts timeouts between SOFs.
// [R12] Enable bit 9 gates SOF/EOP received.
// [R13] Enable bit 8 gates bus reset detected.
// [R14] Bits 7..0 enable endpoint transaction done.
// [R15] Done on ACK, STALL, timeout, IN/OUT exception.
// [R16] NAK also fires done when enabled.
// [R17] Enables reset to zero.
// [R18] Writing one clears pending status flag.
// [R19] Length exception also sets overflow or underflow.
// [R20] Interrupt when flag set and enabled.
// [R21] Reserved enable bits read zero.
module ulri_top (
  input  wire        mclk,
  input  wire        rst_b,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [15:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire        pkt_done,
  input  wire        pkt_dev,
  input  wire [2:0]  pkt_ep,
  input  wire        pkt_out,
  input  wire [9:0]  pkt_count,
  input  wire [10:0] pkt_len,
  input  wire        pkt_ack,
  input  wire        pkt_stall,
  input  wire        pkt_nak,
  input  wire        pkt_tmo,
  input  wire        pkt_crc_err,
  input  wire        pkt_in_exc,
  input  wire        pkt_out_exc,
  input  wire [7:0]  nak_irq_en1,
  input  wire [7:0]  nak_irq_en2,
  input  wire        vbus_valid,
  input  wire        otg_id,
  input  wire [1:0]  sof_rx,
  input  wire [1:0]  sof_tmo,
  input  wire [1:0]  usb_rst_det,
  output reg         dev1_irq,
  output reg         dev2_irq
);
  reg  [15:0] ien1_r;
  reg  [15:0] ien2_r;
  reg  [15:0] stat1_r;
  reg  [15:0] stat2_r;
  reg  [15:0] stat1_nxt;
  reg  [15:0] stat2_nxt;
  reg  [15:0] frame1_r;
  reg  [15:0] frame2_r;
  reg  [15:0] epst_r [0:15];
  reg         vbus_r;
  reg         id_r;
  reg         edge_prime_r;
  reg         rd_pend_r;
  reg  [15:0] rd_mux_r;
  reg         rd_mem_r;
  reg  [15:0] diff;
  reg  [15:0] ep_st_nxt;
  reg  [7:0]  done1;
  reg  [7:0]  done2;
  wire [15:0] mem_rdata;
  wire        setup_ph;
  wire        acc_wr;
  wire        res_hit;
  wire        epst_hit;
  wire        map_hit;
  wire        sw_res_we;
  wire        mem_we;
  wire [3:0]  mem_waddr;
  wire [15:0] mem_wdata;
  wire        len_exc;
  wire        ep_done;
  integer     i;

  // Word index of an address inside an eight-entry window.
  function [2:0] ulri_idx;
    input [15:0] a;
    input [15:0] base;
    reg   [15:0] d;
    begin
      d        = a - base;
      ulri_idx = d[4:2];
    end
  endfunction

  function ulri_in_win;
    input [15:0] a;
    input [15:0] lo;
    input [15:0] hi;
    begin
      ulri_in_win = (a >= lo) && (a <= hi) && (a[1:0] == 2'b00);
    end
  endfunction

  assign setup_ph = psel && !penable;
  // A write lands only at the edge where the master sees pready high.
  assign acc_wr   = psel && penable && pready && pwrite;
  assign res_hit  = ulri_in_win(paddr, `ULRI_OFF_RES_BASE, `ULRI_OFF_RES_END);
  assign epst_hit = ulri_in_win(paddr, `ULRI_OFF_EPST_BASE, `ULRI_OFF_EPST_END);
  // Every register the bus can reach; anything else answers with an error.
  assign map_hit  = res_hit || epst_hit
                 || (paddr == `ULRI_OFF_IEN1) || (paddr == `ULRI_OFF_IEN2)
                 || (paddr == `ULRI_OFF_STAT1) || (paddr == `ULRI_OFF_STAT2)
                 || (paddr == `ULRI_OFF_FRAME1) || (paddr == `ULRI_OFF_FRAME2);
  // The engine owns the memory port; a firmware clear only lands when no packet ends.
  assign sw_res_we = acc_wr && res_hit && !pkt_done; // [R4]
  assign len_exc   = pkt_out && !pkt_crc_err && ({1'b0, pkt_count} != pkt_len); // [R2]
  assign mem_we    = (pkt_done && pkt_out && !pkt_crc_err) || sw_res_we;
  assign mem_waddr = pkt_done ? {pkt_dev, pkt_ep}
                              : {1'b0, ulri_idx(paddr, `ULRI_OFF_RES_BASE)};
  assign mem_wdata = pkt_done ? diff : pwdata[15:0];
  assign ep_done   = pkt_ack || pkt_stall || pkt_tmo || pkt_in_exc || pkt_out_exc; // [R15]

  // Count minus length: negative on overflow with top bits all ones.
  always @*
  begin
    diff = {6'h00, pkt_count} - {5'h00, pkt_len}; // [R1] [R5] [R6]
  end

  ulri_mem #(
    .AW (4),
    .DW (`ULRI_DW)
  ) u_mem (
    .mclk  (mclk),
    .we    (mem_we),
    .waddr (mem_waddr),
    .wdata (mem_wdata),
    .raddr ({1'b0, ulri_idx(paddr, `ULRI_OFF_RES_BASE)}),
    .rdata (mem_rdata)
  );

  // Endpoint status word built for the packet just finished.
  always @*
  begin
    ep_st_nxt                 = `ULRI_ZERO16;
    ep_st_nxt[`ULRI_ST_ACK]   = pkt_ack;
    ep_st_nxt[`ULRI_ST_ERR]   = pkt_crc_err;
    ep_st_nxt[`ULRI_ST_TMO]   = pkt_tmo;
    ep_st_nxt[`ULRI_ST_LEN]   = len_exc; // [R2]
    ep_st_nxt[`ULRI_ST_NAK]   = pkt_nak;
    ep_st_nxt[`ULRI_ST_STALL] = pkt_stall;
    ep_st_nxt[`ULRI_ST_INX]   = pkt_in_exc;
    ep_st_nxt[`ULRI_ST_OUTX]  = pkt_out_exc;
    ep_st_nxt[`ULRI_ST_OVF]   = len_exc && ({1'b0, pkt_count} < pkt_len); // [R19]
    ep_st_nxt[`ULRI_ST_UNF]   = len_exc && ({1'b0, pkt_count} > pkt_len); // [R19]
  end

  always @*
  begin
    done1 = 8'h00;
    done2 = 8'h00;
    if (pkt_done && (ep_done || (pkt_nak && (pkt_dev ? nak_irq_en2[pkt_ep]
                                                     : nak_irq_en1[pkt_ep])))) // [R16]
    begin
      if (pkt_dev)
      begin
        done2[pkt_ep] = 1'b1;
      end
      else
      begin
        done1[pkt_ep] = 1'b1;
      end
    end
  end

  // Hardware set wins over a same-cycle write-one clear.
  always @*
  begin
    stat1_nxt = stat1_r;
    stat2_nxt = stat2_r;
    if (acc_wr && (paddr == `ULRI_OFF_STAT1))
    begin
      stat1_nxt = stat1_r & ~pwdata[15:0]; // [R18]
    end
    if (acc_wr && (paddr == `ULRI_OFF_STAT2))
    begin
      stat2_nxt = stat2_r & ~pwdata[15:0]; // [R18]
    end
    stat1_nxt[7:0] = stat1_nxt[7:0] | done1; // [R15]
    stat2_nxt[7:0] = stat2_nxt[7:0] | done2;
    if (edge_prime_r && (vbus_r != vbus_valid))
    begin
      stat1_nxt[`ULRI_BIT_VBUS] = 1'b1; // [R7] [R9]
    end
    if (edge_prime_r && (id_r != otg_id))
    begin
      stat1_nxt[`ULRI_BIT_ID] = 1'b1; // [R8] [R9]
    end
    if (sof_rx[0])
    begin
      stat1_nxt[`ULRI_BIT_SOF] = 1'b1; // [R12]
    end
    if (sof_rx[1])
    begin
      stat2_nxt[`ULRI_BIT_SOF] = 1'b1;
    end
    if (sof_tmo[0])
    begin
      stat1_nxt[`ULRI_BIT_SOFTO] = 1'b1; // [R10]
    end
    if (sof_tmo[1])
    begin
      stat2_nxt[`ULRI_BIT_SOFTO] = 1'b1;
    end
    if (usb_rst_det[0])
    begin
      stat1_nxt[`ULRI_BIT_URST] = 1'b1; // [R13]
    end
    if (usb_rst_det[1])
    begin
      stat2_nxt[`ULRI_BIT_URST] = 1'b1;
    end
    stat1_nxt = stat1_nxt & `ULRI_IEN1_MASK;
    stat2_nxt = stat2_nxt & `ULRI_IEN2_MASK; // [R9]
  end

  always @(posedge mclk)
  begin
    if (!rst_b)
    begin
      ien1_r       <= `ULRI_IEN_RST; // [R17]
      ien2_r       <= `ULRI_IEN_RST; // [R17]
      stat1_r      <= `ULRI_ZERO16;
      stat2_r      <= `ULRI_ZERO16;
      frame1_r     <= `ULRI_ZERO16;
      frame2_r     <= `ULRI_ZERO16;
      vbus_r       <= 1'b0;
      id_r         <= 1'b0;
      edge_prime_r <= 1'b0;
      dev1_irq     <= 1'b0;
      dev2_irq     <= 1'b0;
      for (i = 0; i < 16; i = i + 1)
      begin
        epst_r[i] <= `ULRI_ZERO16;
      end
    end
    else
    begin
      // First sample after reset only primes the edge detectors.
      vbus_r       <= vbus_valid;
      id_r         <= otg_id;
      edge_prime_r <= 1'b1;
      stat1_r      <= stat1_nxt;
      stat2_r      <= stat2_nxt;
      if (acc_wr && (paddr == `ULRI_OFF_IEN1))
      begin
        ien1_r <= pwdata[15:0] & `ULRI_IEN1_MASK; // [R21]
      end
      if (acc_wr && (paddr == `ULRI_OFF_IEN2))
      begin
        ien2_r <= pwdata[15:0] & `ULRI_IEN2_MASK; // [R9] [R21]
      end
      if (pkt_done)
      begin
        epst_r[{pkt_dev, pkt_ep}] <= ep_st_nxt;
      end
      if (sof_rx[0])
      begin
        frame1_r <= `ULRI_ZERO16; // [R11]
      end
      else if (sof_tmo[0])
      begin
        frame1_r <= frame1_r + 16'h0001; // [R11]
      end
      if (sof_rx[1])
      begin
        frame2_r <= `ULRI_ZERO16;
      end
      else if (sof_tmo[1])
      begin
        frame2_r <= frame2_r + 16'h0001;
      end
      dev1_irq <= |(stat1_r & ien1_r); // [R20] [R7] [R8] [R10] [R12] [R13] [R14]
      dev2_irq <= |(stat2_r & ien2_r); // [R20]
    end
  end

  // Three-cycle access: setup, one wait state, then pready with the read word.
  // The wait lets the registered memory word settle, so prdata stands with pready.
  always @(posedge mclk)
  begin
    if (!rst_b)
    begin
      pready    <= 1'b0;
      pslverr   <= 1'b0;
      prdata    <= `ULRI_ZERO32;
      rd_pend_r <= 1'b0;
      rd_mux_r  <= `ULRI_ZERO16;
      rd_mem_r  <= 1'b0;
    end
    else
    begin
      pready    <= rd_pend_r;
      rd_pend_r <= setup_ph;
      pslverr   <= rd_pend_r && !map_hit;
      rd_mem_r  <= res_hit;
      if (paddr == `ULRI_OFF_IEN1)
        rd_mux_r <= ien1_r;
      else if (paddr == `ULRI_OFF_IEN2)
        rd_mux_r <= ien2_r;
      else if (paddr == `ULRI_OFF_STAT1)
        rd_mux_r <= stat1_r;
      else if (paddr == `ULRI_OFF_STAT2)
        rd_mux_r <= stat2_r;
      else if (paddr == `ULRI_OFF_FRAME1)
        rd_mux_r <= frame1_r;
      else if (paddr == `ULRI_OFF_FRAME2)
        rd_mux_r <= frame2_r;
      else if (epst_hit)
        rd_mux_r <= epst_r[{1'b0, ulri_idx(paddr, `ULRI_OFF_EPST_BASE)}];
      else
        rd_mux_r <= `ULRI_ZERO16;
      if (rd_pend_r)
      begin
        prdata <= {`ULRI_ZERO16, rd_mem_r ? mem_rdata : rd_mux_r};
      end
      else if (setup_ph)
      begin
        prdata <= `ULRI_ZERO32;
      end
    end
  end
endmodule // ulri_top

// *** ulri_top_props.sv ***
// Checker for the length-result and interrupt-enable block.
// Assumes it is bound to ulri_top and sees only that module's ports.
`timescale 1ns/1ns
module ulri_props (
  input wire        mclk,
  input wire        rst_b,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [15:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire        pready,
  input wire        pslverr,
  input wire        pkt_done,
  input wire        pkt_dev,
  input wire [2:0]  pkt_ep,
  input wire        pkt_ack,
  input wire        vbus_valid,
  input wire        dev1_irq
);
  reg  [15:0] ien_r;
  wire        ien_wr = psel && penable && pready && pwrite && paddr == 16'hc08c;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);
  // The enable mask is internal, so a shadow built from bus writes stands in for it.
  always @(posedge mclk)
    if (!rst_b)
      ien_r <= 16'h0000;
    else if (ien_wr)
      ien_r <= pwdata[15:0] & 16'hcbff;
  sequence setup_s;
    psel && !penable;
  endsequence
  a_ready_next: assert property (setup_s |=> !pready ##1 pready) else $error("no ready after setup");
  a_ready_pulse: assert property (pready |=> !pready) else $error("ready held high");
  a_unmapped_err: assert property ((setup_s and paddr[15:12] != 4'hc) |-> ##2 pslverr)
    else $error("no error on unmapped access");
  a_enable_ok: assert property ((setup_s and paddr == 16'hc08c) |-> ##2 !pslverr)
    else $error("error on enable access");
  a_reserved_zero:
    assert property (pready && !pwrite && paddr == 16'hc08c |-> (prdata & 32'hffff3400) == 0)
    else $error("reserved enable bits not zero");
  a_ep_irq:
    assert property (pkt_done && !pkt_dev && pkt_ack && ien_r[pkt_ep] |-> ##[1:3] dev1_irq)
    else $error("endpoint irq missing");
  a_vbus_irq:
    assert property ($changed(vbus_valid) && ien_r[15] |-> ##[1:4] dev1_irq)
    else $error("vbus irq missing");
  a_masked_quiet: assert property ((ien_r == 16'h0000) [*3] |-> !dev1_irq)
    else $error("irq with all enables off");
  a_reset_quiet: assert property (disable iff (1'b0) !rst_b |=> !dev1_irq)
    else $error("irq during reset");
endmodule // ulri_props
bind ulri_top ulri_props u_props (.mclk(mclk), .rst_b(rst_b), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .pkt_done(pkt_done), .pkt_dev(pkt_dev), .pkt_ep(pkt_ep),
  .pkt_ack(pkt_ack), .vbus_valid(vbus_valid), .dev1_irq(dev1_irq));

// *** ulri_host.sv ***
// Host-side model: packet reports and bus events toward the block.
// Assumes its tasks are called from the bench's main process.
`timescale 1ns/1ns
module ulri_host (
  input  wire        mclk,
  output reg         pkt_done,
  output reg         pkt_out,
  output reg  [2:0]  pkt_ep,
  output reg  [9:0]  pkt_count,
  output reg  [10:0] pkt_len,
  output reg  [5:0]  pkt_q,
  output reg         vbus_valid,
  output reg         otg_id,
  output reg  [1:0]  sof_rx,
  output reg  [1:0]  sof_tmo,
  output reg  [1:0]  usb_rst_det
);
  initial {pkt_done, pkt_out, pkt_ep, pkt_count, pkt_len, pkt_q} = 0;
  initial {vbus_valid, otg_id, sof_rx, sof_tmo, usb_rst_det} = 0;
  // Fields are scrambled outside the done pulse so nothing can lean on stale values.
  task pkt(input [2:0] e, input [9:0] c, input [10:0] l, input [5:0] q);
    begin
      @(posedge mclk);
      {pkt_done, pkt_out, pkt_ep, pkt_count, pkt_len, pkt_q} <= {2'b11, e, c, l, q};
      @(posedge mclk);
      {pkt_done, pkt_out, pkt_ep, pkt_count, pkt_len, pkt_q} <= {2'b00, ~e, ~c, ~l, 6'h00};
    end
  endtask
  task ev(input [2:0] k);
    begin
      @(posedge mclk);
      case (k)
        3'd0: usb_rst_det <= 2'b01;
        3'd1: sof_rx <= 2'b01;
        3'd2: sof_tmo <= 2'b01;
        3'd3: otg_id <= ~otg_id;
        default: vbus_valid <= ~vbus_valid;
      endcase
      @(posedge mclk);
      {sof_rx, sof_tmo, usb_rst_det} <= 6'h00;
    end
  endtask
endmodule // ulri_host

// *** ulri_top_tb.sv ***
// Self-checking bench for ulri_top with a host model on the packet side.
// Assumes ulri_defs.vh on the include path.
`timescale 1ns/1ns
`include "ulri_defs.vh"
module ulri_top_tb;
  reg         mclk = 1'b0;
  reg         rst_b = 1'b0;
  reg         psel = 1'b0;
  reg         penable = 1'b0;
  reg         pwrite = 1'b0;
  reg  [15:0] paddr = 16'h0000;
  reg  [31:0] pwdata = 32'h0000_0000;
  reg  [7:0]  nak_irq_en1 = 8'hff;
  reg         pkt_dev = 1'b0;
  reg  [31:0] rs = 32'h0000_0038;
  wire [31:0] prdata;
  wire        pready, pslverr, pkt_done, pkt_out, vbus_valid, otg_id, dev1_irq, dev2_irq;
  wire [2:0]  pkt_ep;
  wire [9:0]  pkt_count;
  wire [10:0] pkt_len;
  wire [5:0]  q;
  wire [1:0]  sof_rx, sof_tmo, usb_rst_det;
  integer     bad_count = 0;
  integer     comparisons = 0;
  integer     i;
  reg  [31:0] r, c, l;
  reg         e, s;
  reg  [4:0]  b;
  always #25 mclk = ~mclk;
  ulri_host u_host (.mclk(mclk), .pkt_done(pkt_done), .pkt_out(pkt_out), .pkt_ep(pkt_ep),
    .pkt_count(pkt_count), .pkt_len(pkt_len), .pkt_q(q), .vbus_valid(vbus_valid),
    .otg_id(otg_id), .sof_rx(sof_rx), .sof_tmo(sof_tmo), .usb_rst_det(usb_rst_det));
  ulri_top u_dut (.mclk(mclk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pkt_done(pkt_done), .pkt_dev(pkt_dev), .pkt_ep(pkt_ep), .pkt_out(pkt_out),
    .pkt_count(pkt_count), .pkt_len(pkt_len), .pkt_ack(q[0]), .pkt_stall(q[1]),
    .pkt_nak(q[5]), .pkt_tmo(q[2]), .pkt_crc_err(1'b0), .pkt_in_exc(q[3]),
    .pkt_out_exc(q[4]), .nak_irq_en1(nak_irq_en1), .nak_irq_en2(8'h00),
    .vbus_valid(vbus_valid), .otg_id(otg_id), .sof_rx(sof_rx), .sof_tmo(sof_tmo),
    .usb_rst_det(usb_rst_det), .dev1_irq(dev1_irq), .dev2_irq(dev2_irq));
  function [31:0] nx(input [31:0] x);
    begin
      nx = x ^ (x << 13);
      nx = nx ^ (nx >> 17);
      nx = nx ^ (nx << 5);
    end
  endfunction
  // Only the 16-bit difference is kept, zero-extended to 32 bits, so overflows read back as 16-bit negatives.
  function [31:0] res_exp(input [9:0] ct, input [10:0] ln);
    res_exp = {16'h0000, 16'(ct) - 16'(ln)};
  endfunction
  function [31:0] st_exp(input [9:0] ct, input [10:0] ln);
    st_exp = {20'h0, ln > ct, ln < ct, 4'h0, ln != ct, 5'h00};
  endfunction
  task final_report;
    begin
      if (bad_count == 0 && comparisons > 0)
        $display("verification passed");
      else
        $display("verification failed");
      $finish;
    end
  endtask
  task cmp(input [31:0] got, input [31:0] exp);
    begin
      comparisons = comparisons + 1;
      if (got !== exp)
      begin
        bad_count = bad_count + 1;
        $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task apb(input w, input [15:0] a, input [31:0] d);
    integer n;
    begin
      n = 0;
      @(posedge mclk);
      {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
      @(posedge mclk);
      penable <= 1'b1;
      do
      begin
        @(posedge mclk);
        n = n + 1;
      end
      while (pready !== 1'b1 && n < 20);
      e = pslverr;
      r = prdata;
      {psel, penable} <= 2'b00;
      if (n >= 20)
      begin
        cmp(0, 1);
        final_report;
      end
    end
  endtask
  task see;
    begin
      s = 1'b0;
      repeat (6)
      begin
        @(posedge mclk);
        if (dev1_irq === 1'b1)
          s = 1'b1;
      end
    end
  endtask
  task fire(input [4:0] k);
    begin
      if (k < 8)
        u_host.pkt(k[2:0], 10'h040, 11'h040, 6'h01 << (k % 6));
      else
        u_host.ev(k == 8 ? 0 : k == 9 ? 1 : k == 11 ? 2 : k == 14 ? 3 : 4);
    end
  endtask
  initial
  begin
    repeat (20) @(posedge mclk);
    rst_b <= 1'b1;
    repeat (2) @(posedge mclk);
    apb(0, `ULRI_OFF_IEN1, 0); cmp(r, 0); cmp({31'h0, e}, 32'h0);
    apb(0, `ULRI_OFF_IEN2, 0); cmp(r, 0);
    apb(1, `ULRI_OFF_IEN1, 32'hffff_ffff); apb(0, `ULRI_OFF_IEN1, 0); cmp(r, 32'hcbff);
    apb(1, `ULRI_OFF_IEN2, 32'hffff_ffff); apb(0, `ULRI_OFF_IEN2, 0); cmp(r, 32'h0bff);
    apb(1, `ULRI_OFF_IEN2, 0);
    apb(0, 16'h1000, 0); cmp({31'h0, e}, 32'h1); cmp(r, 0);
    for (i = 0; i < 13; i = i + 1)
    begin
      b = i < 8 ? i : i == 8 ? 8 : i == 9 ? 9 : i == 10 ? 11 : i == 11 ? 14 : 15;
      apb(1, `ULRI_OFF_IEN1, 32'h1 << b); fire(b); see; cmp(s, 1);
      apb(1, `ULRI_OFF_STAT1, 32'h1 << b); repeat (3) @(posedge mclk); cmp(dev1_irq, 0);
      apb(1, `ULRI_OFF_IEN1, 0); fire(b); see; cmp(s, 0);
      apb(1, `ULRI_OFF_STAT1, 32'h1 << b);
    end
    nak_irq_en1 <= 8'h00;
    apb(1, `ULRI_OFF_IEN1, 32'hff); u_host.pkt(3'd5, 10'h001, 11'h001, 6'h20); see; cmp(s, 0);
    u_host.ev(1); repeat (3) u_host.ev(2);
    apb(0, `ULRI_OFF_FRAME1, 0); cmp(r, 3);
    for (i = 0; i < 8; i = i + 1)
      apb(1, `ULRI_OFF_RES_BASE + 4 * i, 0);
    for (i = 0; i < 24; i = i + 1)
    begin
      rs = nx(rs);
      c = i == 0 ? 1023 : i == 1 ? 0 : i == 2 ? 1023 : i == 3 ? 10 : rs[9:0];
      l = i == 0 ? 2047 : i == 1 ? 0 : i == 2 ? 0 : i == 3 ? 11 : rs[20:10];
      u_host.pkt(rs[31:29], c[9:0], l[10:0], 6'h01);
      apb(0, `ULRI_OFF_EPST_BASE + 4 * rs[31:29], 0); cmp(r & 32'h0c20, st_exp(c, l));
      apb(0, `ULRI_OFF_RES_BASE + 4 * rs[31:29], 0); cmp(r, res_exp(c, l));
    end
    cmp(dev2_irq, 0);
    pkt_dev <= 1'b1;
    apb(1, `ULRI_OFF_IEN2, 32'h4);
    u_host.pkt(3'd2, 10'h010, 11'h010, 6'h01);
    repeat (4) @(posedge mclk);
    cmp(dev2_irq, 1);
    final_report;
  end
endmodule // ulri_top_tb
